// ===== logic/pchr_pkg.sv
// Register map, field layout and reset values for the capability header bank
package pchr_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CAP_HEADER  = 8'h40;
    localparam logic [7:0] ADDR_DEV_CAPS    = 8'h44;
    localparam int         ADDR_W           = 8;
    localparam int         DATA_W           = 32;

    // Capability header fields
    localparam logic [7:0] CAP_ID_VALUE     = 8'h10;
    localparam logic [7:0] NEXT_PTR_RESET   = 8'hc0;
    localparam logic [3:0] VERSION_RESET    = 4'h1;
    localparam logic [3:0] PORT_TYPE_UP     = 4'h5;
    localparam logic [3:0] PORT_TYPE_DOWN   = 4'h6;
    localparam logic       SLOT_RESET       = 1'h0;
    localparam logic [4:0] VECTOR_NUM_VALUE = 5'h00;
    localparam logic       TC_ROUTE_RESET   = 1'h1;
    localparam int         HDR_CAP_ID_LSB   = 0;
    localparam int         HDR_NEXT_LSB     = 8;
    localparam int         HDR_VERSION_LSB  = 16;
    localparam int         HDR_TYPE_LSB     = 20;
    localparam int         HDR_SLOT_BIT     = 24;
    localparam int         HDR_VEC_LSB      = 25;
    localparam int         HDR_TCR_BIT      = 30;

    // Device capabilities fields
    localparam logic [2:0] MAX_PAYLOAD_RESET = 3'h1;
    localparam logic [1:0] PHANTOM_VALUE     = 2'h0;
    localparam logic       EXT_TAG_RESET     = 1'h1;
    localparam logic [2:0] LATENCY_VALUE     = 3'h0;
    localparam logic       PRESENCE_VALUE    = 1'h0;
    localparam logic       ROLE_ERR_VALUE    = 1'h1;
    localparam int         DC_PAYLOAD_LSB    = 0;
    localparam int         DC_PHANTOM_LSB    = 3;
    localparam int         DC_EXT_TAG_BIT    = 5;
    localparam int         DC_L0S_LSB        = 6;
    localparam int         DC_L1_LSB         = 9;
    localparam int         DC_ABTN_BIT       = 12;
    localparam int         DC_AIND_BIT       = 13;
    localparam int         DC_PIND_BIT       = 14;
    localparam int         DC_ROLE_BIT       = 15;
    localparam int         DC_PLV_LSB        = 18;
    localparam int         DC_PLS_LSB        = 26;
    localparam logic [7:0] PLV_RESET         = 8'h00;
    localparam logic [1:0] PLS_RESET         = 2'h0;

    // Bus answer states
    typedef enum logic [0:0] {
        PCHR_IDLE = 1'b0,
        PCHR_RESP = 1'b1
    } pchr_bus_e;
endpackage

// ===== logic/pchr_sync.sv
// Three-stage synchroniser with second/third agreement for pin-level inputs
`timescale 1ns/100ps
module pchr_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    // Raw and cleaned level
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } pchr_sync_s;

    pchr_sync_s st_reg;
    pchr_sync_s st_next;

    // Shift; accept a bit only when stages two and three agree
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = din;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.q[i] = st_reg.s3[i];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.q;
endmodule

// ===== logic/pchr_power_capture.sv
// Captures slot power limit value and scale from a received message strobe
`timescale 1ns/100ps
module pchr_power_capture (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    // Port role
    input  wire logic       upstream,
    // Message from the link layer
    input  wire logic       msg_valid,
    input  wire logic [7:0] msg_value,
    input  wire logic [1:0] msg_scale,
    // Captured fields
    output logic      [7:0] limit_value,
    output logic      [1:0] limit_scale
);
    typedef struct packed {
        logic [7:0] value;
        logic [1:0] scale;
    } pchr_cap_s;

    pchr_cap_s st_reg;
    pchr_cap_s st_next;

    // Load only on the upstream port; downstream stays zero
    always_comb begin
        st_next = st_reg;
        if (!upstream) begin
            st_next.value = pchr_pkg::PLV_RESET;
            st_next.scale = pchr_pkg::PLS_RESET;
        end else if (msg_valid) begin
            st_next.value = msg_value;
            st_next.scale = msg_scale;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign limit_value = st_reg.value;
    assign limit_scale = st_reg.scale;
endmodule

// ===== logic/pchr_regs.sv
// Capability header and device capabilities registers on an Avalon-MM slave
`timescale 1ns/100ps
module pchr_regs (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [1:0]  avs_response,
    // Port strap and lock override pins
    input  wire logic        upstream_port_pin,
    input  wire logic        lock_override_pin,
    // Set slot power limit message from the link layer
    input  wire logic        msg_valid,
    input  wire logic [7:0]  msg_value,
    input  wire logic [1:0]  msg_scale,
    // Captured power limit as seen by the rest of the port
    output logic      [7:0]  power_limit_value,
    output logic      [1:0]  power_limit_scale
);
    typedef struct packed {
        pchr_pkg::pchr_bus_e bus;
        logic                waitreq;
        logic [31:0]         rdata;
        logic [1:0]          resp;
        logic [7:0]          next_ptr;
        logic [3:0]          version;
        logic                slot;
        logic                tc_route;
        logic [2:0]          max_payload;
        logic                ext_tag;
        logic [7:0]          plv_out;
        logic [1:0]          pls_out;
    } pchr_regs_s;

    pchr_regs_s st_reg;
    pchr_regs_s st_next;

    logic [1:0]  pins_sync;
    logic        upstream;
    logic        unlocked;
    logic [7:0]  cap_value;
    logic [1:0]  cap_scale;
    logic [31:0] hdr_word;
    logic [31:0] dcap_word;
    logic [31:0] wmask;

    // Both pins come from outside, so they pass the three-stage filter
    pchr_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .din     ({upstream_port_pin, lock_override_pin}),
        .dout    (pins_sync)
    );
    assign upstream = pins_sync[1];
    assign unlocked = pins_sync[0];

    // Message payload is on clk_sys already, no synchroniser needed
    pchr_power_capture u_cap (
        .clk_sys     (clk_sys),
        .resetn      (resetn),
        .upstream    (upstream),
        .msg_valid   (msg_valid),
        .msg_value   (msg_value),
        .msg_scale   (msg_scale),
        .limit_value (cap_value),
        .limit_scale (cap_scale)
    );

    // Byte-lane mask for writes
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
        end
    end

    // Assemble the header word; bit 31 left zero
    always_comb begin
        hdr_word = '0;
        hdr_word[pchr_pkg::HDR_CAP_ID_LSB +: 8] = pchr_pkg::CAP_ID_VALUE;
        hdr_word[pchr_pkg::HDR_NEXT_LSB +: 8]  = st_reg.next_ptr;
        hdr_word[pchr_pkg::HDR_VERSION_LSB +: 4] = st_reg.version;
        hdr_word[pchr_pkg::HDR_TYPE_LSB +: 4]  = upstream ? pchr_pkg::PORT_TYPE_UP
                                                          : pchr_pkg::PORT_TYPE_DOWN;
        hdr_word[pchr_pkg::HDR_SLOT_BIT]       = st_reg.slot;
        hdr_word[pchr_pkg::HDR_VEC_LSB +: 5]   = pchr_pkg::VECTOR_NUM_VALUE;
        hdr_word[pchr_pkg::HDR_TCR_BIT]        = st_reg.tc_route;
    end

    // Assemble device capabilities; 17:16 and 31:28 left zero
    always_comb begin
        dcap_word = '0;
        dcap_word[pchr_pkg::DC_PAYLOAD_LSB +: 3] = st_reg.max_payload;
        dcap_word[pchr_pkg::DC_PHANTOM_LSB +: 2] = pchr_pkg::PHANTOM_VALUE;
        dcap_word[pchr_pkg::DC_EXT_TAG_BIT]      = st_reg.ext_tag;
        dcap_word[pchr_pkg::DC_L0S_LSB +: 3]     = pchr_pkg::LATENCY_VALUE;
        dcap_word[pchr_pkg::DC_L1_LSB +: 3]      = pchr_pkg::LATENCY_VALUE;
        dcap_word[pchr_pkg::DC_ABTN_BIT]         = pchr_pkg::PRESENCE_VALUE;
        dcap_word[pchr_pkg::DC_AIND_BIT]         = pchr_pkg::PRESENCE_VALUE;
        dcap_word[pchr_pkg::DC_PIND_BIT]         = pchr_pkg::PRESENCE_VALUE;
        dcap_word[pchr_pkg::DC_ROLE_BIT]         = pchr_pkg::ROLE_ERR_VALUE;
        dcap_word[pchr_pkg::DC_PLV_LSB +: 8]     = cap_value;
        dcap_word[pchr_pkg::DC_PLS_LSB +: 2]     = cap_scale;
    end

    // Bus state machine: one wait cycle, then answer with readdata
    always_comb begin
        logic [31:0] mh;
        logic [31:0] md;
        mh      = (hdr_word & ~wmask) | (avs_writedata & wmask);
        md      = (dcap_word & ~wmask) | (avs_writedata & wmask);
        st_next = st_reg;
        st_next.plv_out = cap_value;
        st_next.pls_out = cap_scale;
        unique case (st_reg.bus)
            pchr_pkg::PCHR_IDLE: begin
                if (avs_read || avs_write) begin
                    st_next.bus   = pchr_pkg::PCHR_RESP;
                    st_next.rdata = '0;
                    st_next.resp  = 2'h0;
                    if (avs_address == pchr_pkg::ADDR_CAP_HEADER) begin
                        if (avs_read) begin
                            st_next.rdata = hdr_word;
                        end else if (unlocked) begin
                            st_next.next_ptr = mh[pchr_pkg::HDR_NEXT_LSB +: 8];
                            st_next.version  = mh[pchr_pkg::HDR_VERSION_LSB +: 4];
                            st_next.slot     = mh[pchr_pkg::HDR_SLOT_BIT];
                            st_next.tc_route = mh[pchr_pkg::HDR_TCR_BIT];
                        end
                    end else if (avs_address == pchr_pkg::ADDR_DEV_CAPS) begin
                        if (avs_read) begin
                            st_next.rdata = dcap_word;
                        end else if (unlocked) begin
                            st_next.max_payload = md[pchr_pkg::DC_PAYLOAD_LSB +: 3];
                            st_next.ext_tag     = md[pchr_pkg::DC_EXT_TAG_BIT];
                        end
                    end else begin
                        // Unmapped: reads zero, answers decode error
                        st_next.resp = 2'h3;
                    end
                end
            end
            pchr_pkg::PCHR_RESP: begin
                st_next.bus = pchr_pkg::PCHR_IDLE;
            end
        endcase
        // Kept as its own flop so the bus sees no decode glitch on waitrequest
        st_next.waitreq = (st_next.bus == pchr_pkg::PCHR_IDLE);
    end

    // Register the whole state; lockable fields take their defaults here
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_reg             <= '0;
            st_reg.bus         <= pchr_pkg::PCHR_IDLE;
            st_reg.waitreq     <= 1'b1;
            st_reg.next_ptr    <= pchr_pkg::NEXT_PTR_RESET;
            st_reg.version     <= pchr_pkg::VERSION_RESET;
            st_reg.slot        <= pchr_pkg::SLOT_RESET;
            st_reg.tc_route    <= pchr_pkg::TC_ROUTE_RESET;
            st_reg.max_payload <= pchr_pkg::MAX_PAYLOAD_RESET;
            st_reg.ext_tag     <= pchr_pkg::EXT_TAG_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Waitrequest drops only in the answer cycle, so a request is held
    // while the access is decoded; that costs one cycle per access.
    assign avs_waitrequest   = st_reg.waitreq;
    assign avs_readdata      = st_reg.rdata;
    assign avs_response      = st_reg.resp;
    assign power_limit_value = st_reg.plv_out;
    assign power_limit_scale = st_reg.pls_out;
endmodule

// ===== testbench/pchr_regs_properties.sv
// Concurrent checks on the capability header register bank ports
`timescale 1ns/100ps
module pchr_regs_properties (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        resetn,
    // Bus side
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  avs_response,
    // Strap, message and captured fields
    input wire logic        upstream_port_pin,
    input wire logic        msg_valid,
    input wire logic [7:0]  msg_value,
    input wire logic [1:0]  msg_scale,
    input wire logic [7:0]  power_limit_value,
    input wire logic [1:0]  power_limit_scale
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // Read answer cycles; the master still holds read at that edge
    wire logic rd_hdr = avs_read && !avs_waitrequest && avs_address == 8'h40;
    wire logic rd_dc  = avs_read && !avs_waitrequest && avs_address == 8'h44;

    // Bus answer timing and response code
    chk_answer_one_wait: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("answer not one cycle after request");
    chk_answer_single_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    chk_response_code: assert property ((avs_read || avs_write) && !avs_waitrequest |->
        avs_response ==
        ((avs_address == 8'h40 || avs_address == 8'h44) ? 2'h0 : 2'h3))
        else $error("wrong response code");
    // Fixed header bits; version and pointer are free to move
    chk_header_fixed: assert property (rd_hdr |-> avs_readdata[7:0] == 8'h10
        && avs_readdata[31] == 1'b0 && avs_readdata[29:25] == 5'h00)
        else $error("header fixed bits wrong");
    // Filter settles in four edges, eight stable cycles leave margin
    chk_port_type: assert property (($stable(upstream_port_pin) [*8] ##0 rd_hdr) |->
        avs_readdata[23:20] == (upstream_port_pin ? 4'h5 : 4'h6))
        else $error("port type wrong");
    chk_devcap_fixed: assert property (rd_dc |-> avs_readdata[4:3] == 2'h0
        && avs_readdata[14:6] == 9'h000 && avs_readdata[15] && avs_readdata[17:16] == 2'h0
        && avs_readdata[31:28] == 4'h0)
        else $error("device caps fixed bits wrong");
    chk_down_zero: assert property ((!upstream_port_pin) [*8] |->
        power_limit_value == 8'h00 && power_limit_scale == 2'h0
        && (!rd_dc || avs_readdata[27:18] == 10'h000))
        else $error("downstream captured fields not zero");
    chk_power_capture: assert property ((upstream_port_pin [*8] ##0 msg_valid) |=> ##1
        (power_limit_value == $past(msg_value, 2) && power_limit_scale == $past(msg_scale, 2)))
        else $error("power limit not captured");
endmodule

bind pchr_regs pchr_regs_properties pchr_regs_properties_i (.clk_sys, .resetn, .avs_address,
    .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .avs_response, .upstream_port_pin,
    .msg_valid, .msg_value, .msg_scale, .power_limit_value, .power_limit_scale);

// ===== testbench/test_pchr_regs.sv
// Self-checking bench for the capability header register bank
`timescale 1ns/100ps
module test_pchr_regs;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  avs_response;
    logic        upstream_port_pin = 1'b1;
    logic        lock_override_pin = 1'b0;
    logic        msg_valid = 1'b0;
    logic [7:0]  msg_value = 8'h00;
    logic [1:0]  msg_scale = 2'h0;
    logic [7:0]  power_limit_value;
    logic [1:0]  power_limit_scale;
    logic [31:0] rd;
    logic [1:0]  rs;
    int          n_fail = 0;
    int          total_checks = 0;

    pchr_regs pchr_regs_i (.clk_sys, .resetn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
        .upstream_port_pin, .lock_override_pin, .msg_valid, .msg_value, .msg_scale,
        .power_limit_value, .power_limit_scale);

    // 125 MHz clock
    always #4 clk_sys = ~clk_sys;

    // Counts, verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Compare any value up to one word
    task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One bus access; held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        n = 0;
        // Flops update after this read, so this sees the value at the edge
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            n_fail++;
            $display("MISMATCH %0t bus answer timed out", $time);
            final_report();
        end else begin
            rd = avs_readdata;
            rs = avs_response;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask

    // Read and compare one register
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'h0);
        check32(rd, exp, "readback");
        check32({30'h0, rs}, 32'h0, "read response");
    endtask

    // One-cycle message strobe, then room for the capture to land
    task automatic send_msg(input logic [7:0] v, input logic [1:0] s);
        @(posedge clk_sys);
        msg_valid <= 1'b1;
        msg_value <= v;
        msg_scale <= s;
        @(posedge clk_sys);
        msg_valid <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask

    // Main sequence
    initial begin
        logic [7:0] v;
        logic [1:0] s;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rchk(8'h40, 32'h4051c010);
        rchk(8'h44, 32'h00008021);
        $display("defaults done");
        // Lock off: every write must bounce
        bus(1'b1, 8'h40, 32'hffffffff, 4'hf);
        bus(1'b1, 8'h44, 32'hffffffff, 4'hf);
        rchk(8'h40, 32'h4051c010);
        rchk(8'h44, 32'h00008021);
        $display("lock off done");
        lock_override_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        bus(1'b1, 8'h40, 32'hfeffffff, 4'hf);
        rchk(8'h40, 32'h405fff10);
        bus(1'b1, 8'h40, 32'h00000000, 4'ha);
        rchk(8'h40, 32'h005f0010);
        bus(1'b1, 8'h44, 32'hffffffff, 4'hf);
        rchk(8'h44, 32'h00008027);
        lock_override_pin <= 1'b0;
        $display("lock on done");
        // Every scale code, value from zero to full scale
        for (int i = 0; i < 4; i++) begin
            v = 8'h55 * 8'(i);
            s = 2'(i);
            send_msg(v, s);
            rchk(8'h44, 32'h00008027 | {4'h0, s, v, 18'h0});
            check32({22'h0, rd[27:26], rd[25:18]}, {22'h0, s, v}, "limit fields");
            check32({22'h0, power_limit_scale, power_limit_value}, {22'h0, s, v},
                    "power");
        end
        $display("capture done");
        bus(1'b1, 8'h48, 32'hffffffff, 4'hf);
        check32({30'h0, rs}, 32'h3, "unmapped write response");
        bus(1'b0, 8'h48, 32'h0, 4'h0);
        check32(rd, 32'h0, "unmapped data");
        check32({30'h0, rs}, 32'h3, "unmapped response");
        rchk(8'h40, 32'h005f0010);
        $display("unmapped done");
        upstream_port_pin <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rchk(8'h40, 32'h006f0010);
        rchk(8'h44, 32'h00008027);
        send_msg(8'hff, 2'h3);
        check32({22'h0, power_limit_scale, power_limit_value}, 32'h0, "down power");
        $display("downstream done");
        // Second reset in mid-run restores defaults
        resetn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rchk(8'h40, 32'h4061c010);
        rchk(8'h44, 32'h00008021);
        $display("second reset done");
        final_report();
    end
endmodule
